//--- pump_framer_pkg.sv
/*
 Constants, types and timing for the pump serial command framer.
 Assumes a 10 MHz system clock; rates derive from a 1200 bps base.
*/
package pump_framer_pkg;
    // Clock and line timing
    localparam int CLK_HZ = 10_000_000;
    localparam int BASE_BAUD_BPS = 1200;
    localparam int BASE_BIT_CYCLES = CLK_HZ / BASE_BAUD_BPS;
    localparam logic [2:0] RATE_SEL_MAX = 3'h5;
    localparam logic [5:0] MB_GAP_BITS = 6'h27;
    localparam logic [3:0] LAST_RX_BIT = 4'hA;
    localparam logic [3:0] LAST_TX_BIT = 4'hA;

    // Framing bytes
    localparam logic [7:0] HEAD_FLAG = 8'hE9;
    localparam logic [7:0] ESC_BYTE = 8'hE8;
    localparam logic [7:0] ESC_FOR_E8 = 8'h00;
    localparam logic [7:0] ESC_FOR_E9 = 8'h01;

    // Addressing
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'h1E;
    localparam logic [7:0] BCAST_ADDR = 8'h1F;
    localparam logic [7:0] MB_ADDR_MAX = 8'h20;

    // Command identifiers and lengths
    localparam logic [7:0] ID_SET_0 = 8'h57;
    localparam logic [7:0] ID_READ_0 = 8'h52;
    localparam logic [7:0] ID_J = 8'h4A;
    localparam logic [7:0] SET_LEN = 8'h06;
    localparam logic [7:0] READ_LEN = 8'h02;
    localparam logic [7:0] SET_RESP_LEN = 8'h02;
    localparam logic [7:0] READ_RESP_LEN = 8'h06;
    localparam logic [7:0] PAY_MAX = 8'h06;
    localparam logic [3:0] SET_RESP_LAST = 4'h4;
    localparam logic [3:0] READ_RESP_LAST = 4'h8;

    // Field positions
    localparam int RUN_BIT = 0;
    localparam int FULL_BIT = 1;
    localparam int CW_BIT = 0;

    // Values after reset
    localparam logic [15:0] RST_SPEED = 16'h0000;
    localparam logic RST_RUN = 1'b0;
    localparam logic RST_FULL = 1'b0;
    localparam logic RST_CW = 1'b1;

    typedef enum logic [2:0] {RX_IDLE, RX_ADDR, RX_LEN, RX_PAY, RX_FCS} frame_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_FLAG, TX_DATA, TX_ESC, TX_DONE} tx_st_t;
endpackage

//--- pump_serial_command_framer.sv
/*
 Pump serial command framer: UART, flag framing, unstuffing, command
 decode, response build with stuffing, external start/stop and direction.
 Assumes an external RS485 transceiver steered by tx_drive_out and a
 separate Modbus engine fed from the mb_* byte stream.
*/
// Notes on behaviour
// RQ1 - Character: start, eight data, even parity, stop
// RQ2 - Six selectable rates, 1200 to 38400
// RQ3 - Order: flag, address, length, payload, check
// RQ4 - Frame starts with flag byte E9
// RQ5 - Sending: E8 becomes E8 00, E9 becomes E8 01
// RQ6 - Receiving: pairs revert to E8 and E9
// RQ7 - Escaped pair counts as one byte
// RQ8 - Addresses 1 to 30, 31 broadcasts
// RQ9 - Length equals payload byte count
// RQ10 - Check is XOR of address, length, payload
// RQ11 - Set command stores parameters, answers identifier
// RQ12 - Speed unsigned, most significant byte first
// RQ13 - Speed unit 0.1 rpm or 1 rpm
// RQ14 - Run bit 0, full speed bit 1
// RQ15 - Direction bit 0 set means clockwise
// RQ16 - Broadcast set executes without any response
// RQ17 - Read command answers identifier plus state
// RQ18 - Host never broadcasts a read request
// RQ19 - Start/stop input: level or pulse mode
// RQ20 - Direction input: level or pulse mode
// RQ21 - Flag frames and Modbus frames told apart
// RQ22 - Modbus station address 1 to 32
// RQ23 - Level direction: high clockwise, low counter-clockwise
// RQ24 - Bad check, length or address silently dropped
// RQ25 - Unescaped flag mid-frame restarts parsing
`timescale 1ns/1ps
`default_nettype none

module pump_serial_command_framer
    import pump_framer_pkg::*;
#(
    parameter int BIT_CYCLES_BASE = BASE_BIT_CYCLES,
    parameter bit TENTH_RPM_UNITS = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Serial line
    input wire logic rxd_in,
    output logic txd_out,
    output logic tx_drive_out,
    // Configuration
    input wire logic [2:0] rate_sel_in,
    input wire logic [4:0] unit_addr_in,
    input wire logic [5:0] mb_station_in,
    input wire logic ext_ctrl_in,
    input wire logic start_pulse_mode_in,
    input wire logic dir_pulse_mode_in,
    // External control pins
    input wire logic start_stop_in,
    input wire logic direction_in,
    // Drive state
    output logic [15:0] speed_out,
    output logic speed_tenth_rpm_out,
    output logic run_out,
    output logic full_speed_out,
    output logic cw_out,
    output logic params_set_out,
    // Modbus byte stream
    output logic mb_frame_start_out,
    output logic mb_byte_valid_out,
    output logic [7:0] mb_byte_out
);

    localparam logic [13:0] BASE_W = 14'(BIT_CYCLES_BASE);

    typedef struct packed {
        logic [2:0] rx_sync;
        logic rx_line;
        logic [2:0] ss_sync;
        logic ss_lvl;
        logic ss_half;
        logic ext_run;
        logic [2:0] dir_sync;
        logic dir_lvl;
        logic dir_half;
        logic ext_cw;
        logic rx_busy;
        logic [13:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [9:0] rx_sh;
        logic [5:0] gap;
        logic mb_on;
        logic mb_first;
        logic mb_valid;
        logic [7:0] mb_byte;
        frame_st_t fst;
        logic esc;
        logic [7:0] addr;
        logic [7:0] len;
        logic [2:0] idx;
        logic [7:0] chk;
        logic [5:0][7:0] pay;
        logic [15:0] speed;
        logic run;
        logic full;
        logic cw;
        logic set_pulse;
        logic run_o;
        logic cw_o;
        tx_st_t tst;
        logic [8:0][7:0] resp;
        logic [3:0] resp_last;
        logic [3:0] tidx;
        logic tx_busy;
        logic [13:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [10:0] tx_sh;
        logic de;
    } state_t;

    state_t s;
    state_t n;
    logic [2:0] rsel;
    logic [13:0] bit_len;
    logic [13:0] half;
    logic got;
    logic [7:0] rb;
    logic flag_ok;
    logic dv;
    logic [7:0] d;
    logic hit;
    logic mb_ok;
    logic exec_set;
    logic exec_read;
    logic bad_fcs;
    logic ld;
    logic [7:0] tb;
    logic [7:0] x;

    always_comb begin
        n = s;
        x = '0;
        got = 1'b0;
        rb = '0;
        dv = 1'b0;
        d = '0;
        exec_set = 1'b0;
        exec_read = 1'b0;
        bad_fcs = 1'b0;
        ld = 1'b0;
        tb = '0;
        n.set_pulse = 1'b0;
        n.mb_first = 1'b0;
        n.mb_valid = 1'b0;
        rsel = (rate_sel_in > RATE_SEL_MAX) ? RATE_SEL_MAX : rate_sel_in;
        bit_len = BASE_W >> rsel; // RQ2
        half = bit_len >> 1;
        hit = (s.addr == BCAST_ADDR) || ((s.addr == {3'b000, unit_addr_in})
            && ({3'b000, unit_addr_in} >= ADDR_MIN) && ({3'b000, unit_addr_in} <= ADDR_MAX)); // RQ8
        mb_ok = ({2'b00, mb_station_in} >= ADDR_MIN) && ({2'b00, mb_station_in} <= MB_ADDR_MAX); // RQ22

        // Pin synchronisers, change taken when second and third agree
        n.rx_sync = {s.rx_sync[1:0], rxd_in};
        n.ss_sync = {s.ss_sync[1:0], start_stop_in};
        n.dir_sync = {s.dir_sync[1:0], direction_in};
        if (s.rx_sync[1] == s.rx_sync[2]) begin
            n.rx_line = s.rx_sync[2];
        end
        if (s.ss_sync[1] == s.ss_sync[2]) begin
            n.ss_lvl = s.ss_sync[2];
        end
        if (s.dir_sync[1] == s.dir_sync[2]) begin
            n.dir_lvl = s.dir_sync[2];
        end

        // External inputs: level follows, pulse toggles on every second change
        if (!start_pulse_mode_in) begin
            n.ext_run = s.ss_lvl; // RQ19
            n.ss_half = 1'b0;
        end else if (n.ss_lvl != s.ss_lvl) begin
            n.ss_half = !s.ss_half;
            n.ext_run = s.ss_half ? !s.ext_run : s.ext_run; // RQ19
        end
        if (!dir_pulse_mode_in) begin
            n.ext_cw = s.dir_lvl; // RQ20 RQ23
            n.dir_half = 1'b0;
        end else if (n.dir_lvl != s.dir_lvl) begin
            n.dir_half = !s.dir_half;
            n.ext_cw = s.dir_half ? !s.ext_cw : s.ext_cw; // RQ20
        end

        // Receive character
        if (!s.rx_busy) begin
            n.rx_cnt = (s.rx_cnt >= bit_len - 14'd1) ? '0 : s.rx_cnt + 14'd1;
            if ((s.rx_cnt >= bit_len - 14'd1) && (s.gap != 6'h3F)) begin
                n.gap = s.gap + 6'd1;
            end
            if (!s.rx_line && !s.de) begin
                n.rx_busy = 1'b1;
                n.rx_cnt = '0;
                n.rx_bit = '0;
            end
        end else begin
            n.rx_cnt = s.rx_cnt + 14'd1;
            if (s.rx_cnt == ((s.rx_bit == 4'd0) ? half : bit_len - 14'd1)) begin
                n.rx_cnt = '0;
                if (s.rx_bit == 4'd0) begin
                    n.rx_busy = !s.rx_line;
                    n.rx_bit = 4'd1;
                end else begin
                    n.rx_sh = {s.rx_line, s.rx_sh[9:1]};
                    n.rx_bit = s.rx_bit + 4'd1;
                    if (s.rx_bit == LAST_RX_BIT) begin
                        n.rx_busy = 1'b0;
                        n.gap = '0;
                        got = n.rx_sh[9] && !(^n.rx_sh[8:0]); // RQ1
                        rb = n.rx_sh[7:0];
                        if (!got) begin
                            n.fst = RX_IDLE;
                        end
                    end
                end
            end
        end

        // Modbus frames: bytes outside flag frames after a silent gap
        flag_ok = got && (rb == HEAD_FLAG) && !(s.mb_on && (s.gap < MB_GAP_BITS)); // RQ21
        if (got && !flag_ok && (s.fst == RX_IDLE)) begin
            if (s.gap >= MB_GAP_BITS) begin
                n.mb_on = (rb == {2'b00, mb_station_in}) && mb_ok; // RQ21 RQ22
                n.mb_first = n.mb_on;
            end
            if (n.mb_on) begin
                n.mb_valid = 1'b1;
                n.mb_byte = rb;
            end
        end

        // Flag detection and unstuffing
        if (flag_ok) begin
            n.fst = RX_ADDR; // RQ4 RQ25
            n.esc = 1'b0;
            n.chk = '0;
            n.mb_on = 1'b0;
        end else if (got && (s.fst != RX_IDLE)) begin
            if (s.esc) begin
                n.esc = 1'b0;
                if (rb == ESC_FOR_E8) begin
                    dv = 1'b1; // RQ6 RQ7
                    d = ESC_BYTE;
                end else if (rb == ESC_FOR_E9) begin
                    dv = 1'b1; // RQ6 RQ7
                    d = HEAD_FLAG;
                end else begin
                    n.fst = RX_IDLE; // RQ24
                end
            end else if (rb == ESC_BYTE) begin
                n.esc = 1'b1;
            end else begin
                dv = 1'b1;
                d = rb;
            end
        end

        // Frame fields
        if (dv) begin
            unique case (s.fst)
                RX_IDLE: begin
                end
                RX_ADDR: begin
                    n.addr = d; // RQ3
                    n.chk = s.chk ^ d; // RQ10
                    n.fst = RX_LEN;
                end
                RX_LEN: begin
                    n.len = d;
                    n.chk = s.chk ^ d; // RQ10
                    n.idx = '0;
                    if (d > PAY_MAX) begin
                        n.fst = RX_IDLE; // RQ24
                    end else begin
                        n.fst = (d == 8'h00) ? RX_FCS : RX_PAY;
                    end
                end
                RX_PAY: begin
                    n.pay[s.idx] = d;
                    n.chk = s.chk ^ d; // RQ10
                    n.idx = s.idx + 3'd1;
                    if ({5'b00000, s.idx} == s.len - 8'd1) begin
                        n.fst = RX_FCS; // RQ9
                    end
                end
                RX_FCS: begin
                    n.fst = RX_IDLE;
                    if ((d == s.chk) && hit) begin // RQ24
                        exec_set = (s.len == SET_LEN) && (s.pay[0] == ID_SET_0)
                            && (s.pay[1] == ID_J); // RQ11
                        exec_read = (s.len == READ_LEN) && (s.pay[0] == ID_READ_0)
                            && (s.pay[1] == ID_J) && (s.addr != BCAST_ADDR); // RQ17 RQ18
                    end else begin
                        bad_fcs = 1'b1;
                    end
                end
            endcase
        end

        // Command execution and response build
        if (exec_set) begin
            n.speed = {s.pay[2], s.pay[3]}; // RQ12
            n.run = s.pay[4][RUN_BIT]; // RQ14
            n.full = s.pay[4][FULL_BIT]; // RQ14
            n.cw = s.pay[5][CW_BIT]; // RQ15
            n.set_pulse = 1'b1;
            if (s.addr != BCAST_ADDR) begin // RQ16
                n.resp[0] = s.addr;
                n.resp[1] = SET_RESP_LEN;
                n.resp[2] = ID_SET_0;
                n.resp[3] = ID_J;
                n.resp_last = SET_RESP_LAST;
                n.tst = TX_FLAG;
            end
        end
        if (exec_read) begin
            n.resp[0] = s.addr;
            n.resp[1] = READ_RESP_LEN;
            n.resp[2] = ID_READ_0;
            n.resp[3] = ID_J;
            n.resp[4] = s.speed[15:8]; // RQ12
            n.resp[5] = s.speed[7:0];
            n.resp[6] = {6'b000000, s.full, s.run};
            n.resp[7] = {7'b0000000, s.cw};
            n.resp_last = READ_RESP_LAST;
            n.tst = TX_FLAG; // RQ17
        end
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n.resp_last)) begin
                x = x ^ n.resp[i]; // RQ10
            end
        end
        if (n.tst == TX_FLAG && s.tst == TX_IDLE) begin
            n.resp[n.resp_last] = x;
            n.tidx = '0;
            n.de = 1'b1;
        end

        // Transmit sequencer with stuffing
        if (!s.tx_busy) begin
            unique case (s.tst)
                TX_IDLE: begin
                end
                TX_FLAG: begin
                    ld = 1'b1;
                    tb = HEAD_FLAG; // RQ3 RQ4
                    n.tst = TX_DATA;
                end
                TX_DATA: begin
                    ld = 1'b1;
                    if ((s.resp[s.tidx] == ESC_BYTE) || (s.resp[s.tidx] == HEAD_FLAG)) begin
                        tb = ESC_BYTE; // RQ5
                        n.tst = TX_ESC;
                    end else begin
                        tb = s.resp[s.tidx];
                        n.tidx = s.tidx + 4'd1;
                        n.tst = (s.tidx == s.resp_last) ? TX_DONE : TX_DATA;
                    end
                end
                TX_ESC: begin
                    ld = 1'b1;
                    tb = (s.resp[s.tidx] == ESC_BYTE) ? ESC_FOR_E8 : ESC_FOR_E9; // RQ5
                    n.tidx = s.tidx + 4'd1;
                    n.tst = (s.tidx == s.resp_last) ? TX_DONE : TX_DATA;
                end
                TX_DONE: begin
                    n.de = 1'b0;
                    n.tst = TX_IDLE;
                end
            endcase
        end

        // Transmit character
        if (ld) begin
            n.tx_sh = {1'b1, ^tb, tb, 1'b0}; // RQ1
            n.tx_busy = 1'b1;
            n.tx_cnt = '0;
            n.tx_bit = '0;
        end else if (s.tx_busy) begin
            n.tx_cnt = s.tx_cnt + 14'd1;
            if (s.tx_cnt == bit_len - 14'd1) begin
                n.tx_cnt = '0;
                n.tx_sh = {1'b1, s.tx_sh[10:1]};
                n.tx_bit = s.tx_bit + 4'd1;
                n.tx_busy = (s.tx_bit != LAST_TX_BIT);
            end
        end

        n.run_o = ext_ctrl_in ? n.ext_run : n.run;
        n.cw_o = ext_ctrl_in ? n.ext_cw : n.cw;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s <= '0;
            s.rx_sync <= '1;
            s.rx_line <= 1'b1;
            s.tx_sh <= '1;
            s.speed <= RST_SPEED;
            s.run <= RST_RUN;
            s.full <= RST_FULL;
            s.cw <= RST_CW;
            s.cw_o <= RST_CW;
        end else begin
            s <= n;
        end
    end

    assign txd_out = s.tx_sh[0];
    assign tx_drive_out = s.de;
    assign speed_out = s.speed;
    assign speed_tenth_rpm_out = TENTH_RPM_UNITS; // RQ13
    assign run_out = s.run_o;
    assign full_speed_out = s.full;
    assign cw_out = s.cw_o;
    assign params_set_out = s.set_pulse;
    assign mb_frame_start_out = s.mb_first;
    assign mb_byte_valid_out = s.mb_valid;
    assign mb_byte_out = s.mb_byte;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence seq_flag_load;
        ld && (s.tst == TX_FLAG);
    endsequence
    sequence seq_stuff_load;
        ld && (s.tst == TX_DATA) && ((s.resp[s.tidx] == ESC_BYTE) || (s.resp[s.tidx] == HEAD_FLAG));
    endsequence
    sequence seq_bcast_set;
        exec_set && (s.addr == BCAST_ADDR);
    endsequence

    AST_CHAR_FORMAT: assert property (ld |=> !s.tx_sh[0] && s.tx_sh[10] && !(^s.tx_sh[9:1])) // RQ1
        else $error("transmitted character framing or parity wrong");
    AST_FLAG_FIRST: assert property (seq_flag_load |=> s.tx_sh[8:1] == HEAD_FLAG) // RQ4
        else $error("response did not start with head flag");
    AST_STUFF: assert property (seq_stuff_load |=> s.tx_sh[8:1] == ESC_BYTE && s.tst == TX_ESC) // RQ5
        else $error("flag or escape byte sent unstuffed");
    AST_BCAST_SILENT: assert property (seq_bcast_set |=> (s.tst == TX_IDLE && !s.de) [*2]) // RQ16
        else $error("broadcast set produced a response");
    AST_SET_APPLY: assert property (exec_set |=> s.run == $past(s.pay[4][RUN_BIT])
        && s.full == $past(s.pay[4][FULL_BIT]) && s.speed == {$past(s.pay[2]), $past(s.pay[3])}) // RQ14
        else $error("set command fields not applied");
    AST_BAD_DROP: assert property (bad_fcs |=> $stable(s.speed) && s.tst == $past(s.tst)) // RQ24
        else $error("bad frame changed state or answered");
    AST_RESYNC: assert property (flag_ok |=> s.fst == RX_ADDR && s.chk == 8'h00) // RQ25
        else $error("head flag did not restart the parser");
    AST_READ_RESP: assert property (exec_read |=> s.tst == TX_FLAG && s.de
        && s.resp_last == READ_RESP_LAST && s.resp[2] == ID_READ_0) // RQ17
        else $error("read request not answered with state");
    AST_LEVEL_DIR: assert property ((!dir_pulse_mode_in && ext_ctrl_in) [*2]
        |=> s.cw_o == $past(s.dir_lvl)) // RQ23
        else $error("level direction not followed");

endmodule // pump_serial_command_framer

`default_nettype wire

//--- pump_host_model.sv
/*
 Host side of the serial link: sends stuffed flag frames and collects replies.
 Assumes the framer's bit length is BASE >> rate select, with the line idle high.
*/
`timescale 1ns/1ps
`default_nettype none

module pump_host_model #(
    parameter int BASE = 64
) (
    // Clock and rate
    input wire logic clk_in,
    input wire logic [2:0] rate_sel_in,
    // Serial line
    input wire logic txd_in,
    output var logic rxd_out
);
    int bit_len;
    bit busy;
    bit rx_err;
    logic [7:0] rx_q[$];

    always_comb bit_len = BASE >> rate_sel_in;
    initial rxd_out = 1'b1;

    task automatic put_bit(input logic b);
        rxd_out <= b;
        repeat (bit_len) @(posedge clk_in);
    endtask

    // Start, eight data bits LSB first, even parity, stop
    task automatic put_byte(input logic [7:0] b);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(b[i]);
        put_bit(^b);
        put_bit(1'b1);
    endtask

    task automatic put_stuffed(input logic [7:0] b);
        if (b == 8'hE8 || b == 8'hE9) begin
            put_byte(8'hE8);
            put_byte(b - 8'hE8);
        end else begin
            put_byte(b);
        end
    endtask

    // Skews of length and check let a scenario send a faulty frame
    task automatic send_frame(input logic [7:0] addr, input logic [7:0] pay[$],
        input logic [7:0] len_adj, input logic [7:0] fcs_adj);
        logic [7:0] len;
        logic [7:0] fcs;
        busy = 1'b1;
        len = 8'(pay.size()) + len_adj;
        fcs = addr ^ len ^ fcs_adj;
        foreach (pay[i]) fcs ^= pay[i];
        put_byte(8'hE9);
        put_stuffed(addr);
        put_stuffed(len);
        foreach (pay[i]) put_stuffed(pay[i]);
        put_stuffed(fcs);
        busy = 1'b0;
    endtask

    // Ends after 400 quiet cycles past our own sending
    task automatic recv_frame(output bit got);
        logic [9:0] s;
        logic [7:0] b;
        bit esc;
        int n;
        rx_q.delete();
        rx_err = 1'b0;
        got = 1'b0;
        esc = 1'b0;
        n = 0;
        while (n < 400) begin
            @(posedge clk_in);
            n = busy ? 0 : n + 1;
            if (txd_in === 1'b0) begin
                repeat (bit_len / 2) @(posedge clk_in);
                for (int i = 0; i < 10; i++) begin
                    repeat (bit_len) @(posedge clk_in);
                    s[i] = txd_in;
                end
                b = s[7:0];
                if (s[9] !== 1'b1 || ^s[8:0] !== 1'b0) rx_err = 1'b1;
                if (rx_q.size() > 0 && b === 8'hE9) rx_err = 1'b1;
                if (esc) begin
                    rx_q.push_back(8'hE8 + b);
                    esc = 1'b0;
                    if (b > 8'h01) rx_err = 1'b1;
                end else if (b === 8'hE8 && rx_q.size() > 0) begin
                    esc = 1'b1;
                end else begin
                    rx_q.push_back(b);
                end
                got = 1'b1;
                n = 0;
            end
        end
    endtask
endmodule // pump_host_model

`default_nettype wire

//--- test_pump_serial_command_framer.sv
/*
 Self-checking bench for the pump serial command framer.
 Assumes pump_host_model as the host and a short base bit length of 64.
*/
`timescale 1ns/1ps
`default_nettype none

module test_pump_serial_command_framer
    import pump_framer_pkg::*;
;
    localparam int BASE = 64;
    logic clk, arst_n, rxd, txd, drv, ext_ctrl, sp_mode, dp_mode, ss_pin, dir_pin;
    logic [2:0] rate_sel;
    logic [4:0] unit_addr;
    logic [5:0] station;
    logic [15:0] speed;
    logic tenth, run, full, cw, pset, mb_start, mb_valid;
    logic [7:0] mb_byte;
    int bad_count, total_checks, sets, mb_starts, mb_bytes;
    logic [7:0] pay[$];
    logic [7:0] rsp[$];
    logic [7:0] adr[3] = '{8'h06, 8'h05, 8'h05};
    logic [7:0] ladj[3] = '{8'h00, 8'h00, 8'hFF};
    logic [7:0] fadj[3] = '{8'h00, 8'h01, 8'h00};

    pump_serial_command_framer #(.BIT_CYCLES_BASE(BASE), .TENTH_RPM_UNITS(1'b1)) DUT (
        .ref_clk_in(clk), .arst_n_in(arst_n), .rxd_in(rxd), .txd_out(txd),
        .tx_drive_out(drv), .rate_sel_in(rate_sel), .unit_addr_in(unit_addr),
        .mb_station_in(station), .ext_ctrl_in(ext_ctrl), .start_pulse_mode_in(sp_mode),
        .dir_pulse_mode_in(dp_mode), .start_stop_in(ss_pin), .direction_in(dir_pin),
        .speed_out(speed), .speed_tenth_rpm_out(tenth), .run_out(run),
        .full_speed_out(full), .cw_out(cw), .params_set_out(pset),
        .mb_frame_start_out(mb_start), .mb_byte_valid_out(mb_valid), .mb_byte_out(mb_byte));

    pump_host_model #(.BASE(BASE)) host (
        .clk_in(clk), .rate_sel_in(rate_sel), .txd_in(txd), .rxd_out(rxd));

    always @(posedge clk) begin
        if (pset === 1'b1) sets++;
        if (mb_start === 1'b1) mb_starts++;
        if (mb_valid === 1'b1) mb_bytes++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One request; rsp holds the expected reply payload, empty for none
    task automatic cmd(input logic [7:0] addr, input logic [7:0] la, input logic [7:0] fa);
        logic [7:0] x;
        bit got;
        fork
            host.send_frame(addr, pay, la, fa);
            host.recv_frame(got);
        join
        chk("reply_seen", rsp.size() != 0, got);
        if (rsp.size() != 0) begin
            x = addr ^ 8'(rsp.size());
            foreach (rsp[i]) x ^= rsp[i];
            rsp = {8'hE9, addr, 8'(rsp.size()), rsp, x};
            chk("reply_len", rsp.size(), host.rx_q.size());
            foreach (rsp[i]) chk("reply_byte", rsp[i], host.rx_q[i]);
            chk("reply_wire", 0, host.rx_err);
        end
        @(posedge clk);
    endtask

    task automatic chk_state(input logic [15:0] s, input logic r, input logic f, input logic c,
        input int n);
        chk("speed", s, speed);
        chk("run", r, run);
        chk("full", f, full);
        chk("cw", c, cw);
        chk("sets", n, sets);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        test_done();
    end

    initial begin
        {arst_n, ext_ctrl, sp_mode, dp_mode, ss_pin, dir_pin} = 6'b00_0001;
        rate_sel = 3'h1;
        unit_addr = 5'h05;
        station = 6'h07;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk_state(RST_SPEED, RST_RUN, RST_FULL, RST_CW, 0);
        chk("idle", 2'b10, {txd, drv});
        chk("unit", 1'b1, tenth);
        pay = '{8'h57, 8'h4A, 8'h01, 8'hF4, 8'h01, 8'h01};
        rsp = '{8'h57, 8'h4A};
        cmd(8'h05, 8'h00, 8'h00);
        chk_state(16'h01F4, 1'b1, 1'b0, 1'b1, 1);
        pay = '{8'h57, 8'h4A, 8'hE8, 8'hE9, 8'h02, 8'h00};
        rsp = '{8'h57, 8'h4A};
        cmd(8'h05, 8'h00, 8'h00);
        chk_state(16'hE8E9, 1'b0, 1'b1, 1'b0, 2);
        for (int r = 0; r < 3; r++) begin
            rate_sel <= 3'(r);
            @(posedge clk);
            pay = '{8'h52, 8'h4A};
            rsp = '{8'h52, 8'h4A, 8'hE8, 8'hE9, 8'h02, 8'h00};
            cmd(8'h05, 8'h00, 8'h00);
        end
        rate_sel <= 3'h1;
        @(posedge clk);
        pay = '{8'h57, 8'h4A, 8'h00, 8'h64, 8'h03, 8'h01};
        rsp = {};
        cmd(8'h1F, 8'h00, 8'h00);
        chk_state(16'h0064, 1'b1, 1'b1, 1'b1, 3);
        pay = '{8'h52, 8'h4A};
        cmd(8'h1F, 8'h00, 8'h00);
        pay = '{8'h57, 8'h4A, 8'h00, 8'h11, 8'h00, 8'h00};
        for (int i = 0; i < 3; i++) cmd(adr[i], ladj[i], fadj[i]);
        chk_state(16'h0064, 1'b1, 1'b1, 1'b1, 3);
        unit_addr <= 5'(adr[0]);
        @(posedge clk);
        rsp = '{8'h57, 8'h4A};
        cmd(adr[0], 8'h00, 8'h00);
        chk_state(16'h0011, 1'b0, 1'b0, 1'b0, 4);
        unit_addr <= 5'h05;
        host.put_byte(8'hE9);
        host.put_byte(8'h05);
        host.put_byte(8'h06);
        pay = '{8'h57, 8'h4A, 8'h00, 8'h22, 8'h01, 8'h00};
        rsp = '{8'h57, 8'h4A};
        cmd(8'h05, 8'h00, 8'h00);
        chk_state(16'h0022, 1'b1, 1'b0, 1'b0, 5);
        for (int m = 0; m < 2; m++) begin
            station <= 6'(8 - m);
            repeat (40 * 32) @(posedge clk);
            host.put_byte(8'h07);
            host.put_byte(m ? 8'hE9 : 8'h05);
            host.put_byte(8'h03);
        end
        repeat (40 * 32) @(posedge clk);
        chk("mb_start", 1, mb_starts);
        chk("mb_bytes", 3, mb_bytes);
        chk("mb_byte", 8'h03, mb_byte);
        chk("sets", 5, sets);
        ext_ctrl <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            {ss_pin, dir_pin} <= {2{1'(d)}};
            repeat (10) @(posedge clk);
            chk("ext_run", d, run);
            chk("ext_cw", d, cw);
        end
        {sp_mode, dp_mode} <= 2'b11;
        repeat (10) @(posedge clk);
        for (int d = 0; d < 2; d++) begin
            {ss_pin, dir_pin} <= {2{1'(d)}};
            repeat (10) @(posedge clk);
        end
        chk("pulse_run", 0, run);
        chk("pulse_cw", 0, cw);
        test_done();
    end
endmodule // test_pump_serial_command_framer

`default_nettype wire
